// >>> mpwm_pkg.sv
package mpwm_pkg;

	// ==========================================================
	// Sizing and clock figures
	// ==========================================================
	localparam int unsigned MPWM_PHASES = 4; // Most phase outputs supported.
	localparam int unsigned MPWM_CLK_KHZ = 50000; // Reference clock rate in kHz.
	localparam int unsigned MPWM_SW_KHZ = 280; // Default switching_frequency in kHz.
	localparam int unsigned MPWM_PER_W = 16; // Width of a switching period count.
	localparam int unsigned MPWM_VAL_W = 12; // Width of voltage and current samples.
	localparam logic [15:0] MPWM_PERIOD_RST = 16'(MPWM_CLK_KHZ / MPWM_SW_KHZ); // Clocks per cycle.

	// ==========================================================
	// Sequence lengths, counted in switching cycles
	// ==========================================================
	localparam logic [11:0] MPWM_INIT_WAIT = 12'h020; // First three-state wait (32 cycles).
	localparam logic [11:0] MPWM_OC_WAIT = 12'h800; // Three-state wait after over-current (2048).
	localparam logic [11:0] MPWM_CLAMP_LEN = 12'h096; // Low clamp interval (150 cycles).
	localparam logic [11:0] MPWM_PG_CYCLE = 12'h800; // Power-good allowed from this cycle (2048).

	// ==========================================================
	// Thresholds in percent of the programmed value
	// ==========================================================
	localparam logic [7:0] MPWM_OV_PCT = 8'h73; // Over-voltage trip at 115 percent.
	localparam logic [7:0] MPWM_OV_HYS_PCT = 8'h71; // Over-voltage release at 113 percent.
	localparam logic [7:0] MPWM_UV_SET_PCT = 8'h5a; // Under-voltage set below 90 percent.
	localparam logic [7:0] MPWM_UV_CLR_PCT = 8'h5c; // Under-voltage clear at 92 percent.
	localparam logic [7:0] MPWM_OC_PCT = 8'ha5; // Over-current trip at 165 percent.

	// ==========================================================
	// Register byte offsets and reset values
	// ==========================================================
	localparam logic [7:0] MPWM_ADDR_PERIOD = 8'h00; // Switching period in clocks.
	localparam logic [7:0] MPWM_ADDR_DUTY = 8'h04; // Regulated duty in clocks.
	localparam logic [7:0] MPWM_ADDR_TARGET = 8'h08; // Programmed core voltage target code.
	localparam logic [7:0] MPWM_ADDR_OC_NOM = 8'h0c; // Full-load nominal phase current.
	localparam logic [7:0] MPWM_ADDR_TRIM = 8'h10; // Balance pulse-width trim in clocks.
	localparam logic [7:0] MPWM_ADDR_STATUS = 8'h14; // Sequencer status, read only.
	localparam logic [7:0] MPWM_ADDR_REF_NOW = 8'h18; // Present reference ramp value.
	localparam logic [7:0] MPWM_ADDR_CYCLES = 8'h1c; // Start sequence cycle count.
	localparam logic [15:0] MPWM_DUTY_RST = 16'h0040; // Default regulated duty.
	localparam logic [11:0] MPWM_TARGET_RST = 12'h800; // Default voltage target code.
	localparam logic [11:0] MPWM_OC_NOM_RST = 12'h400; // Default nominal current code.
	localparam logic [15:0] MPWM_TRIM_RST = 16'h0002; // Default balance trim.
	localparam logic [11:0] MPWM_REF_STEP = 12'h001; // Reference rise per switching cycle.

	// ==========================================================
	// Sequencer states, Gray coded along the start path
	// ==========================================================
	typedef enum logic [2:0] {
		MPWM_ST_OFF = 3'b000, // Power-on reset held, outputs three-state.
		MPWM_ST_WAIT = 3'b001, // Initial three-state wait, reference inhibited.
		MPWM_ST_CLAMP = 3'b011, // Outputs driven low.
		MPWM_ST_RAMP = 3'b010, // Duty and reference rising.
		MPWM_ST_RUN = 3'b110, // Regulated pulsing.
		MPWM_ST_OC = 3'b111, // Over-current hiccup wait.
		MPWM_ST_OV = 3'b101 // Over-voltage latched.
	} mpwm_state_e;

	// Status word fields, packed from the top down.
	typedef struct packed {
		logic [19:0] zero; // Reads as zero.
		logic pg; // Power-good output level.
		logic oc; // Over-current present now.
		logic uv; // Under-voltage present now.
		logic ov; // Over-voltage latch.
		logic [2:0] count; // Active phase count.
		logic [2:0] state; // Sequencer state code.
		logic [1:0] spare; // Reads as zero.
	} mpwm_status_s;

endpackage

// >>> mpwm_seq.sv
// Behaviour
// - Up to four phases, count from tied pins.
// - Phases spaced one period over count.
// - Reset held keeps all outputs three-state.
// - Supply good starts; supply loss shuts down.
// - First 32 cycles three-state, reference inhibited.
// - From cycle 33, outputs low ~150 cycles.
// - Then duty ramps from zero to regulated.
// - No power-good before cycle 2048.
// - Reference rises per cycle to target.
// - Over-voltage above 115 percent of target.
// - Over-voltage latch until supply loss or a new reset.
// - Latched: low above limit, three-state below hysteresis.
// - Under 90 percent drops power-good, hysteretic.
// - Over-current forces three-state, starts wait.
// - Over-current restart wait is 2048 cycles.
// - After wait restart ramp; repeat as hiccup.
// - Power-good low during over-current wait.
// - Above-average phase gets shorter pulse.
// - Average current over 165 percent trips.
//
// Design decisions made here: the APB register port and the register offsets.
module mpwm_seq
	import mpwm_pkg::*;
#(
	parameter int unsigned PHASES = MPWM_PHASES, // Phase outputs.
	parameter int unsigned PER_W = MPWM_PER_W, // Period count width.
	parameter int unsigned VAL_W = MPWM_VAL_W // Sample width.
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// APB register port.
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Board pins, asynchronous.
	input wire logic i_supply_good,
	input wire logic [PHASES-1:0] i_phase_tied,
	// Converted samples from the sensing front end, on this clock.
	input wire logic [VAL_W-1:0] i_core_voltage_sense,
	input wire logic [PHASES*VAL_W-1:0] i_phase_current,
	// Phase outputs to the gate drivers, and the power-good output.
	output logic [PHASES-1:0] o_pwm_out,
	output logic [PHASES-1:0] o_pwm_oe,
	output logic o_power_good_out
);

	// ==========================================================
	// Helper functions
	// ==========================================================

	// Returns value times percent over one hundred.
	function automatic logic [VAL_W+1:0] pct_of(input logic [VAL_W-1:0] v, input logic [7:0] p);
		logic [VAL_W+7:0] prod;
		prod = (VAL_W+8)'(v) * (VAL_W+8)'(p);
		return (VAL_W+2)'(prod / (VAL_W+8)'(100));
	endfunction

	// Divides by the active phase count, one to four.
	function automatic logic [PER_W+1:0] div_count(input logic [PER_W+1:0] v, input logic [2:0] n);
		case (n)
			3'd2: return v >> 1;
			3'd3: return v / (PER_W+2)'(3);
			3'd4: return v >> 2;
			default: return v;
		endcase
	endfunction

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic sg_meta_reg; // First stage, read only by the second.
	logic sg_sync_reg; // Synchronised supply good.
	logic [PHASES-1:0] tie_meta_reg; // First stage, read only by the second.
	logic [PHASES-1:0] tie_sync_reg; // Synchronised tie straps.

	// Two flip-flops per pin before any logic looks at it.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sg_meta_reg <= 1'b0;
			sg_sync_reg <= 1'b0;
			tie_meta_reg <= '0;
			tie_sync_reg <= '0;
		end else begin
			sg_meta_reg <= i_supply_good;
			sg_sync_reg <= sg_meta_reg;
			tie_meta_reg <= i_phase_tied;
			tie_sync_reg <= tie_meta_reg;
		end
	end

	// ==========================================================
	// Registers and state declarations
	// ==========================================================
	logic [PER_W-1:0] period_reg; // Switching period in clocks.
	logic [PER_W-1:0] duty_reg; // Regulated duty in clocks.
	logic [VAL_W-1:0] target_reg; // Programmed voltage target.
	logic [VAL_W-1:0] oc_nom_reg; // Nominal full-load current.
	logic [PER_W-1:0] trim_reg; // Balance trim in clocks.
	logic [PER_W-1:0] osc_reg; // Oscillator count within a period.
	logic cyc_tick; // One-cycle pulse at end of each period.
	mpwm_state_e state_reg; // Sequencer state.
	logic [11:0] st_cnt_reg; // Cycles spent in the present state.
	logic [11:0] seq_cnt_reg; // Cycles since the start sequence began.
	logic [PER_W-1:0] ramp_duty_reg; // Soft-start duty.
	logic [VAL_W-1:0] ref_reg; // Internal reference ramp.
	logic [2:0] count_reg; // Active phase count.
	logic ov_latch_reg; // Over-voltage latch.
	logic ov_clamp_reg; // Hysteretic clamp while latched.
	logic uv_reg; // Under-voltage flag.
	logic pg_reg; // Power-good output register.
	logic [PHASES-1:0] pwm_reg; // Phase output levels.
	logic [PHASES-1:0] oe_reg; // Phase output enables.
	logic [VAL_W+1:0] ov_limit; // Over-voltage trip level.
	logic [VAL_W+1:0] ov_release; // Over-voltage release level.
	logic [VAL_W+1:0] uv_set_lvl; // Under-voltage set level.
	logic [VAL_W+1:0] uv_clr_lvl; // Under-voltage clear level.
	logic [VAL_W+1:0] avg_cur; // Average of active phase currents.
	logic over_volt; // Sense above the trip level.
	logic over_cur; // Average above the trip level.
	logic [2:0] tied_count; // Untied phases seen on the pins.

	// ==========================================================
	// APB slave
	// ==========================================================
	logic apb_setup; // Setup cycle of a transfer.
	logic apb_write; // Write taken at this edge.
	logic addr_hit; // Address maps to a register.
	logic [31:0] rd_mux; // Read data selected by address.
	mpwm_status_s status; // Status word.

	assign apb_setup = i_psel && !i_penable;
	assign apb_write = i_psel && i_penable && i_pwrite;
	assign o_pready = 1'b1;

	// Build the status word from live state.
	always_comb begin
		status = '0;
		status.pg = pg_reg;
		status.oc = over_cur;
		status.uv = uv_reg;
		status.ov = ov_latch_reg;
		status.count = count_reg;
		status.state = state_reg;
	end

	// Decode the address and select read data.
	always_comb begin
		addr_hit = 1'b1;
		rd_mux = '0;
		case (i_paddr)
			MPWM_ADDR_PERIOD: rd_mux = 32'(period_reg);
			MPWM_ADDR_DUTY: rd_mux = 32'(duty_reg);
			MPWM_ADDR_TARGET: rd_mux = 32'(target_reg);
			MPWM_ADDR_OC_NOM: rd_mux = 32'(oc_nom_reg);
			MPWM_ADDR_TRIM: rd_mux = 32'(trim_reg);
			MPWM_ADDR_STATUS: rd_mux = status;
			MPWM_ADDR_REF_NOW: rd_mux = 32'(ref_reg);
			MPWM_ADDR_CYCLES: rd_mux = 32'(seq_cnt_reg);
			default: addr_hit = 1'b0;
		endcase
	end

	// An unmapped address errors in the access phase.
	assign o_pslverr = i_psel && i_penable && !addr_hit;

	// Read data is captured in the setup cycle and held through access.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_prdata <= '0;
		end else if (apb_setup) begin
			o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	// Software writable registers.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			period_reg <= PER_W'(MPWM_PERIOD_RST);
			duty_reg <= PER_W'(MPWM_DUTY_RST);
			target_reg <= VAL_W'(MPWM_TARGET_RST);
			oc_nom_reg <= VAL_W'(MPWM_OC_NOM_RST);
			trim_reg <= PER_W'(MPWM_TRIM_RST);
		end else if (apb_write) begin
			case (i_paddr)
				MPWM_ADDR_PERIOD: period_reg <= i_pwdata[PER_W-1:0];
				MPWM_ADDR_DUTY: duty_reg <= i_pwdata[PER_W-1:0];
				MPWM_ADDR_TARGET: target_reg <= i_pwdata[VAL_W-1:0];
				MPWM_ADDR_OC_NOM: oc_nom_reg <= i_pwdata[VAL_W-1:0];
				MPWM_ADDR_TRIM: trim_reg <= i_pwdata[PER_W-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Switching oscillator
	// ==========================================================
	assign cyc_tick = (osc_reg >= period_reg - PER_W'(1));

	// Free-running period counter; every sequence count keys off its tick.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			osc_reg <= '0;
		end else if (cyc_tick) begin
			osc_reg <= '0;
		end else begin
			osc_reg <= osc_reg + PER_W'(1);
		end
	end

	// ==========================================================
	// Fault detection
	// ==========================================================
	always_comb begin
		ov_limit = pct_of(target_reg, MPWM_OV_PCT);
		ov_release = pct_of(target_reg, MPWM_OV_HYS_PCT);
		uv_set_lvl = pct_of(target_reg, MPWM_UV_SET_PCT);
		uv_clr_lvl = pct_of(target_reg, MPWM_UV_CLR_PCT);
	end

	assign over_volt = (VAL_W+2)'(i_core_voltage_sense) > ov_limit;

	// Average the active phase currents.
	always_comb begin
		logic [PER_W+1:0] sum;
		sum = '0;
		for (int k = 0; k < PHASES; k++) begin
			if (k < int'(count_reg)) begin
				sum = sum + (PER_W+2)'(i_phase_current[k*VAL_W +: VAL_W]);
			end
		end
		avg_cur = (VAL_W+2)'(div_count(sum, count_reg));
	end

	assign over_cur = avg_cur > pct_of(oc_nom_reg, MPWM_OC_PCT);

	// Count of untied phase pins; unused phases are the upper ones.
	always_comb begin
		tied_count = '0;
		for (int k = 0; k < PHASES; k++) begin
			if (!tie_sync_reg[k]) begin
				tied_count = tied_count + 3'd1;
			end
		end
	end

	// ==========================================================
	// Start and protection sequencer
	// ==========================================================
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= MPWM_ST_OFF;
			st_cnt_reg <= '0;
			seq_cnt_reg <= '0;
			count_reg <= 3'd1;
		end else if (!sg_sync_reg) begin
			state_reg <= MPWM_ST_OFF;
			st_cnt_reg <= '0;
			seq_cnt_reg <= '0;
		end else begin
			case (state_reg)
				MPWM_ST_OFF: begin
					// Supply is good: catch the phase straps and begin.
					count_reg <= (tied_count == 3'd0) ? 3'd1 : tied_count;
					state_reg <= MPWM_ST_WAIT;
				end
				MPWM_ST_WAIT, MPWM_ST_OC: begin
					// Three-state wait, 32 cycles normally, 2048 after over-current.
					if (cyc_tick) begin
						st_cnt_reg <= st_cnt_reg + 12'd1;
						if (st_cnt_reg == ((state_reg == MPWM_ST_OC) ?
								MPWM_OC_WAIT : MPWM_INIT_WAIT) - 12'd1) begin
							state_reg <= MPWM_ST_CLAMP;
							st_cnt_reg <= '0;
						end
					end
				end
				MPWM_ST_CLAMP: begin
					if (cyc_tick) begin
						st_cnt_reg <= st_cnt_reg + 12'd1;
						if (st_cnt_reg == MPWM_CLAMP_LEN - 12'd1) begin
							state_reg <= MPWM_ST_RAMP;
							st_cnt_reg <= '0;
						end
					end
				end
				MPWM_ST_RAMP: begin
					if (ramp_duty_reg >= duty_reg && ref_reg >= target_reg) begin
						state_reg <= MPWM_ST_RUN;
					end
				end
				MPWM_ST_RUN: ;
				MPWM_ST_OV: ; // Only a supply drop or a reset leaves this state.
				default: state_reg <= MPWM_ST_OFF;
			endcase
			// Start cycle count, saturating once power-good is allowed.
			if (cyc_tick && state_reg != MPWM_ST_OFF && seq_cnt_reg < MPWM_PG_CYCLE) begin
				seq_cnt_reg <= seq_cnt_reg + 12'd1;
			end
			// Faults override the path above; over-voltage takes priority.
			if (state_reg != MPWM_ST_OFF && over_volt) begin
				state_reg <= MPWM_ST_OV;
			end else if (over_cur && (state_reg == MPWM_ST_CLAMP ||
					state_reg == MPWM_ST_RAMP || state_reg == MPWM_ST_RUN)) begin
				state_reg <= MPWM_ST_OC;
				st_cnt_reg <= '0;
				seq_cnt_reg <= '0;
			end
			if (state_reg == MPWM_ST_OV) begin
				state_reg <= MPWM_ST_OV;
			end
		end
	end

	assign ov_latch_reg = (state_reg == MPWM_ST_OV);

	// Hysteretic clamp while latched: low above limit, released below.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ov_clamp_reg <= 1'b0;
		end else if (state_reg != MPWM_ST_OV) begin
			ov_clamp_reg <= 1'b1;
		end else if (over_volt) begin
			ov_clamp_reg <= 1'b1;
		end else if ((VAL_W+2)'(i_core_voltage_sense) < ov_release) begin
			ov_clamp_reg <= 1'b0;
		end
	end

	// Soft-start duty and reference ramps, one step per switching cycle.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ramp_duty_reg <= '0;
			ref_reg <= '0;
		end else if (state_reg != MPWM_ST_RAMP && state_reg != MPWM_ST_RUN) begin
			ramp_duty_reg <= '0;
			ref_reg <= '0;
		end else if (cyc_tick) begin
			if (ramp_duty_reg < duty_reg) begin
				ramp_duty_reg <= ramp_duty_reg + PER_W'(1);
			end else begin
				ramp_duty_reg <= duty_reg;
			end
			if (ref_reg + MPWM_REF_STEP < target_reg) begin
				ref_reg <= ref_reg + MPWM_REF_STEP;
			end else begin
				ref_reg <= target_reg;
			end
		end
	end

	// ==========================================================
	// Power-good monitor
	// ==========================================================
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			uv_reg <= 1'b1;
		end else if ((VAL_W+2)'(i_core_voltage_sense) < uv_set_lvl) begin
			uv_reg <= 1'b1;
		end else if ((VAL_W+2)'(i_core_voltage_sense) >= uv_clr_lvl) begin
			uv_reg <= 1'b0;
		end
	end

	// Power-good needs running pulses, no faults and the full start count.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pg_reg <= 1'b0;
		end else begin
			pg_reg <= (state_reg == MPWM_ST_RAMP || state_reg == MPWM_ST_RUN)
				&& seq_cnt_reg >= MPWM_PG_CYCLE
				&& !uv_reg && !over_cur;
		end
	end

	assign o_power_good_out = pg_reg;

	// ==========================================================
	// Interleaved phase outputs
	// ==========================================================
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		logic [PER_W+1:0] step;
		logic [PER_W+1:0] pos;
		logic [PER_W-1:0] duty;
		if (!i_rst_b) begin
			pwm_reg <= '0;
			oe_reg <= '0;
		end else begin
			step = div_count((PER_W+2)'(period_reg), count_reg);
			for (int k = 0; k < PHASES; k++) begin
				// Phase position: oscillator plus k steps, wrapped to the period.
				pos = (PER_W+2)'(osc_reg) + step * (PER_W+2)'(k);
				if (pos >= (PER_W+2)'(period_reg)) begin
					pos = pos - (PER_W+2)'(period_reg);
				end
				// A phase above average current loses the trim.
				duty = (state_reg == MPWM_ST_RUN) ? duty_reg : ramp_duty_reg;
				if ((VAL_W+2)'(i_phase_current[k*VAL_W +: VAL_W]) > avg_cur) begin
					duty = (duty > trim_reg) ? duty - trim_reg : '0;
				end
				case (state_reg)
					MPWM_ST_CLAMP: begin
						pwm_reg[k] <= 1'b0;
						oe_reg[k] <= (k < int'(count_reg));
					end
					MPWM_ST_RAMP, MPWM_ST_RUN: begin
						pwm_reg[k] <= (pos < (PER_W+2)'(duty));
						oe_reg[k] <= (k < int'(count_reg)) && !over_cur;
					end
					MPWM_ST_OV: begin
						pwm_reg[k] <= 1'b0;
						oe_reg[k] <= (k < int'(count_reg)) && ov_clamp_reg;
					end
					default: begin
						pwm_reg[k] <= 1'b0;
						oe_reg[k] <= 1'b0;
					end
				endcase
			end
		end
	end

	assign o_pwm_out = pwm_reg;
	assign o_pwm_oe = oe_reg;

endmodule // mpwm_seq

// >>> mpwm_monitor.sv
// ==========================================================
// Port checker
// ==========================================================
module mpwm_monitor
	import mpwm_pkg::*;
#(
	parameter int unsigned PHASES = MPWM_PHASES, // Phase outputs.
	parameter int unsigned VAL_W = MPWM_VAL_W // Sample width.
) (
	// Clock, reset and register bus.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Pins and outputs.
	input wire logic i_supply_good,
	input wire logic [PHASES-1:0] i_phase_tied,
	input wire logic [VAL_W-1:0] i_core_voltage_sense,
	input wire logic [PHASES-1:0] o_pwm_out,
	input wire logic [PHASES-1:0] o_pwm_oe,
	input wire logic o_power_good_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] per_reg; // Period shadow.
	logic [11:0] tgt_reg; // Target shadow.
	logic [31:0] up_reg; // Clocks of supply good.
	logic [31:0] vs; // Wide sense.
	assign vs = 32'(i_core_voltage_sense);
	// Shadows track bus writes.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			per_reg <= MPWM_PERIOD_RST;
			tgt_reg <= MPWM_TARGET_RST;
		end else if (i_psel && i_penable && i_pwrite) begin
			if (i_paddr == MPWM_ADDR_PERIOD) per_reg <= i_pwdata[15:0];
			if (i_paddr == MPWM_ADDR_TARGET) tgt_reg <= i_pwdata[11:0];
		end
	end
	// Counts supply-good clocks.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) up_reg <= '0;
		else up_reg <= i_supply_good ? up_reg + 32'h1 : '0;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	AST_RST_QUIET: assert property ($rose(i_rst_b) |->
		((o_pwm_oe == '0) && !o_power_good_out) [*3]) else $error("reset leak");
	AST_PHASE_MASK: assert property ((o_pwm_oe == '0) || (o_pwm_oe == ~i_phase_tied))
		else $error("phase mask");
	AST_WAIT_TRISTATE: assert property ($rose(|o_pwm_oe) |->
		up_reg > {16'h0, per_reg} * 32'h1f) else $error("early enable");
	AST_CLAMP_LOW: assert property ($rose(|o_pwm_oe) |->
		((o_pwm_out & o_pwm_oe) == '0) [*8]) else $error("no low clamp");
	AST_PG_LATE: assert property ($rose(o_power_good_out) |->
		up_reg > {16'h0, per_reg} * 32'h7ff) else $error("early power good");
	AST_SUPPLY_OFF: assert property (!i_supply_good [*6] |->
		(o_pwm_oe == '0) && !o_power_good_out) else $error("on without supply");
	AST_OV_CLAMP: assert property ((vs > {20'h0, tgt_reg} * 32'h73 / 32'h64) [*4] |->
		((o_pwm_out & o_pwm_oe) == '0) && !o_power_good_out) else $error("no ov clamp");
	AST_UV_PG: assert property ((vs < {20'h0, tgt_reg} * 32'h5a / 32'h64) [*3] |->
		!o_power_good_out) else $error("pg under voltage");
	AST_BUS_ANSWER: assert property (i_psel && i_penable |-> o_pready &&
		(o_pslverr == ((i_paddr > 8'h1c) || (i_paddr[1:0] != 2'h0)))) else $error("bad bus answer");
endmodule // mpwm_monitor

// >>> mpwm_gate_model.sv
// ==========================================================
// Gate drivers, three-state aware
// ==========================================================
module mpwm_gate_model (
	// Clock and phase levels.
	input wire logic i_ref_clk,
	input wire logic [3:0] i_pwm_out,
	input wire logic [3:0] i_pwm_oe,
	// Switch commands.
	output logic [3:0] o_high_on,
	output logic [3:0] o_low_on
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released level: both switches off.
	assign o_high_on = i_pwm_oe & i_pwm_out;
	assign o_low_on = i_pwm_oe & ~i_pwm_out;
	int cyc = 0; // Clock count.
	int rise_c [4] = '{default: 0}; // Last upper turn-on.
	int wid [4] = '{default: 0}; // Last pulse width.
	int run [4] = '{default: 0}; // Pulse in progress.
	logic [3:0] prev = '0; // Upper one clock ago.
	// Pulse edges and widths.
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		prev <= o_high_on;
		for (int k = 0; k < 4; k++) begin
			if (o_high_on[k] && !prev[k]) rise_c[k] <= cyc;
			if (o_high_on[k]) begin
				run[k] <= run[k] + 1;
			end else begin
				if (run[k] != 0) wid[k] <= run[k];
				run[k] <= 0;
			end
		end
	end
endmodule // mpwm_gate_model

// >>> tb_top.sv
module tb_top
	import mpwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 8; // Period in clocks.
	localparam int TGT = int'(MPWM_TARGET_RST); // Reset target.
	localparam logic [11:0] CUR_OK = 12'h200; // Safe phase current.
	logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, supply = 1'b0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, pg, er;
	logic [3:0] tied = '0, pwm_out, pwm_oe, hi_on;
	logic [11:0] sense = MPWM_TARGET_RST;
	logic [47:0] cur = {4{CUR_OK}};
	int errors = 0, check_count = 0, cycles = 0, waited = 0;
	// Clock at 50 MHz.
	initial forever #10 clk = ~clk;
	mpwm_seq i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_supply_good(supply), .i_phase_tied(tied),
		.i_core_voltage_sense(sense), .i_phase_current(cur), .o_pwm_out(pwm_out),
		.o_pwm_oe(pwm_oe), .o_power_good_out(pg));
	mpwm_gate_model i_gate (.i_ref_clk(clk), .i_pwm_out(pwm_out), .i_pwm_oe(pwm_oe),
		.o_high_on(hi_on), .o_low_on());
	task automatic complete_run();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask
	// One bus transfer, held until ready.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic x);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
		chk({31'h0, er}, {31'h0, x});
	endtask
	function automatic logic [31:0] look(input bit sel);
		return sel ? {31'h0, pg} : {28'h0, pwm_oe};
	endfunction
	// Bounded wait, then compare.
	task automatic wait_on(input bit sel, input logic [3:0] v, input int lim);
		waited = 0;
		while (look(sel) !== {28'h0, v} && waited < lim) begin
			@(posedge clk);
			waited++;
		end
		chk(look(sel), {28'h0, v});
	endtask
	task automatic t_regs();
		logic [7:0] ad [5] = '{MPWM_ADDR_PERIOD, MPWM_ADDR_DUTY, MPWM_ADDR_TARGET,
			MPWM_ADDR_OC_NOM, MPWM_ADDR_TRIM};
		logic [31:0] ex [5] = '{32'(MPWM_PERIOD_RST), 32'(MPWM_DUTY_RST),
			32'(MPWM_TARGET_RST), 32'(MPWM_OC_NOM_RST), 32'(MPWM_TRIM_RST)};
		for (int k = 0; k < 5; k++) rchk(ad[k], ex[k], 1'b0);
		apb(1'b1, MPWM_ADDR_REF_NOW, 32'hfff);
		rchk(MPWM_ADDR_REF_NOW, 32'h0, 1'b0);
		rchk(8'h20, 32'h0, 1'b1);
		apb(1'b1, MPWM_ADDR_PERIOD, 32'(PER));
		apb(1'b1, MPWM_ADDR_DUTY, 32'h4);
		rchk(MPWM_ADDR_PERIOD, 32'(PER), 1'b0);
	endtask
	task automatic t_start();
		supply <= 1'b1;
		repeat (30 * PER) @(posedge clk);
		chk(look(0), 32'h0);
		wait_on(0, 4'hf, 10 * PER);
		repeat (140 * PER) @(posedge clk);
		chk({24'h0, hi_on, pwm_oe}, 32'h0f);
		wait_on(1, 4'h1, 2100 * PER);
		repeat (300 * PER) @(posedge clk);
		rchk(MPWM_ADDR_STATUS, 32'h898, 1'b0);
		rchk(MPWM_ADDR_REF_NOW, 32'(TGT), 1'b0);
		rchk(MPWM_ADDR_CYCLES, 32'h800, 1'b0);
		cur <= {CUR_OK, 12'h300, CUR_OK, CUR_OK};
		repeat (4 * PER) @(posedge clk);
		for (int k = 0; k < 4; k++) chk(32'(i_gate.wid[k]), (k == 2) ? 32'h2 : 32'h4);
		for (int k = 0; k < 3; k++) begin
			chk(32'(((i_gate.rise_c[k] - i_gate.rise_c[k + 1]) % PER + PER) % PER), 32'(PER / 4));
		end
		cur <= {4{CUR_OK}};
	endtask
	task automatic t_uv();
		sense <= 12'(TGT * 89 / 100);
		wait_on(1, 4'h0, 10);
		sense <= 12'(TGT * 91 / 100);
		repeat (20) @(posedge clk);
		chk({27'h0, pg, pwm_oe}, 32'h0f);
		sense <= 12'(TGT);
		wait_on(1, 4'h1, 10);
	endtask
	task automatic t_oc();
		cur <= {4{12'(MPWM_OC_NOM_RST * 170 / 100)}};
		wait_on(0, 4'h0, 5);
		chk(look(1), 32'h0);
		cur <= {4{CUR_OK}};
		wait_on(0, 4'hf, 2100 * PER);
		chk(32'(waited > 2040 * PER), 32'h1);
		chk({28'h0, hi_on}, 32'h0);
		cur <= {4{12'(MPWM_OC_NOM_RST * 170 / 100)}};
		wait_on(0, 4'h0, 5);
		cur <= {4{CUR_OK}};
	endtask
	task automatic t_ov();
		sense <= 12'(TGT * 116 / 100);
		wait_on(0, 4'hf, 8);
		chk({27'h0, pwm_out, pg}, 32'h0);
		sense <= 12'(TGT * 112 / 100);
		wait_on(0, 4'h0, 8);
		sense <= 12'(TGT * 114 / 100);
		repeat (20) @(posedge clk);
		chk(look(0), 32'h0);
		sense <= 12'(TGT * 116 / 100);
		wait_on(0, 4'hf, 8);
		sense <= 12'(TGT);
		wait_on(0, 4'h0, 8);
		rchk(MPWM_ADDR_STATUS, 32'h194, 1'b0);
		supply <= 1'b0;
		tied <= 4'h8;
		repeat (10) @(posedge clk);
		supply <= 1'b1;
		repeat (10) @(posedge clk);
		rchk(MPWM_ADDR_STATUS, 32'h064, 1'b0);
		wait_on(0, 4'h7, 40 * PER);
	endtask
	// Timeout.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			errors++;
			complete_run();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		chk(look(0), 32'h0);
		rst_b <= 1'b1;
		t_regs();
		t_start();
		t_uv();
		t_oc();
		t_ov();
		complete_run();
	end
endmodule // tb_top
bind mpwm_seq mpwm_monitor #(.PHASES(PHASES), .VAL_W(VAL_W)) i_mon (.i_ref_clk(i_ref_clk),
	.i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_supply_good(i_supply_good), .i_phase_tied(i_phase_tied),
	.i_core_voltage_sense(i_core_voltage_sense), .o_pwm_out(o_pwm_out), .o_pwm_oe(o_pwm_oe),
	.o_power_good_out(o_power_good_out));
